// ### flash_front_defs.vh
// Shared constants of the serial flash host interface front end
`ifndef FLASH_FRONT_DEFS_VH
`define FLASH_FRONT_DEFS_VH

// Command codes that change the lane count
`define CMD_DUAL_OUT 8'h3B
`define CMD_DUAL_IO 8'hBB
`define CMD_QUAD_OUT 8'h6B
`define CMD_QUAD_IO 8'hEB

// Lane width codes
`define LANES_1 2'h0
`define LANES_2 2'h1
`define LANES_4 2'h2

// Timing
`define CLK_PERIOD_NS 100
`define RESET_PULSE_MIN_NS 1000
`define RESET_PULSE_MIN_CYC ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### flash_spi_front.v
// Serial flash host interface front end: lanes, pause and hardware reset
`include "flash_front_defs.vh"
module flash_spi_front #(
  parameter HAS_DEDICATED_RESET = 0
) (
  input wire clk,
  input wire rst_n,
  input wire sclk,
  input wire cs_n,
  input wire [3:0] io_i,
  output reg [3:0] io_o,
  output reg [3:0] io_oe,
  input wire reset_pin_n,
  input wire wide_lane_enable,
  input wire pin_func_reset,
  input wire tx_dir,
  input wire [7:0] tx_data,
  output reg tx_req,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg cmd_valid,
  output reg cmd_refused,
  output reg paused,
  output reg iface_reset,
  output reg hw_reset,
  output reg standby
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CMD = 5'h02;
  localparam [4:0] ST_RX = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  wire rise;
  wire fall;
  wire shared_fire;
  wire ded_fire;
  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] rx_sh_q;
  reg [7:0] tx_sh_q;
  reg [1:0] rx_lanes_q;
  reg [1:0] tx_lanes_q;
  reg relock_q;
  reg [3:0] step;
  reg [7:0] rx_next;
  reg [7:0] tx_cur;
  reg [3:0] tx_bits;
  reg [3:0] tx_en;

  // Pin function and lane enable decide what the shared IO3 pin means
  wire hold_mode = ~wide_lane_enable & ~pin_func_reset;
  wire shared_rst_en = ~wide_lane_enable & pin_func_reset;
  wire rst_fire = shared_fire | ded_fire;
  wire active = ~cs_n & ~paused & ~relock_q;
  wire rise_ok = rise & active;
  wire fall_ok = fall & active;

  sclk_edge u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .rise(rise),
    .fall(fall)
  );

  reset_filter u_shared_rst (
    .clk(clk),
    .rst_n(rst_n),
    .enable(shared_rst_en),
    .pin_n(io_i[3]),
    .fire(shared_fire)
  );

  // A dedicated pin ignores the lane enable entirely
  reset_filter u_ded_rst (
    .clk(clk),
    .rst_n(rst_n),
    .enable(HAS_DEDICATED_RESET != 0),
    .pin_n(reset_pin_n),
    .fire(ded_fire)
  );

  // Lane-dependent shifting, most significant bits first
  always @* begin
    case (rx_lanes_q)
      `LANES_2: rx_next = {rx_sh_q[5:0], io_i[1:0]};
      `LANES_4: rx_next = {rx_sh_q[3:0], io_i[3:0]};
      default: rx_next = {rx_sh_q[6:0], io_i[0]};
    endcase
    case (state_q == ST_TX ? tx_lanes_q : rx_lanes_q)
      `LANES_2: step = 4'h2;
      `LANES_4: step = 4'h4;
      default: step = 4'h1;
    endcase
    tx_cur = (cnt_q == 4'h0) ? tx_data : tx_sh_q;
    case (tx_lanes_q)
      `LANES_2: begin
        tx_bits = {2'h0, tx_cur[7:6]};
        tx_en = 4'h3;
      end
      `LANES_4: begin
        tx_bits = tx_cur[7:4];
        tx_en = 4'hF;
      end
      default: begin
        tx_bits = {2'h0, tx_cur[7], 1'b0};
        tx_en = 4'h2;
      end
    endcase
  end

  // Pause tracking; level checks with the clock low give the deferral
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      paused <= 1'b0;
      relock_q <= 1'b0;
      iface_reset <= 1'b0;
    end else begin
      iface_reset <= 1'b0;
      if (rst_fire || !hold_mode) begin
        paused <= 1'b0;
        relock_q <= 1'b0;
      end else if (cs_n) begin
        if (paused) begin
          relock_q <= 1'b1;
          iface_reset <= 1'b1;
        end else if (io_i[3]) begin
          relock_q <= 1'b0;
        end
        paused <= 1'b0;
      end else if (!sclk && !relock_q) begin
        paused <= ~io_i[3];
      end
    end
  end

  // Transaction engine; pause freezes it without touching the core's
  // program or erase work, which runs on regardless
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      rx_lanes_q <= `LANES_1;
      tx_lanes_q <= `LANES_1;
      io_o <= 4'h0;
      io_oe <= 4'h0;
      tx_req <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_refused <= 1'b0;
      hw_reset <= 1'b0;
      standby <= 1'b1;
    end else begin
      tx_req <= 1'b0;
      rx_valid <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_refused <= 1'b0;
      hw_reset <= rst_fire;
      if (rst_fire || cs_n || (paused && !active) || relock_q) begin
        // Outputs float on deselect, pause or reset
        io_oe <= 4'h0;
        if (rst_fire || cs_n || relock_q) begin
          state_q <= ST_IDLE;
          cnt_q <= 4'h0;
          rx_lanes_q <= `LANES_1;
          tx_lanes_q <= `LANES_1;
          standby <= 1'b1;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_CMD;
            standby <= 1'b0;
          end
          ST_CMD, ST_RX: begin
            if (rise_ok) begin
              rx_sh_q <= rx_next;
              if (cnt_q + step == 4'h8) begin
                cnt_q <= 4'h0;
                rx_byte <= rx_next;
                state_q <= tx_dir ? ST_TX : ST_RX;
                if (state_q == ST_CMD) begin
                  cmd_valid <= 1'b1;
                  case (rx_next)
                    `CMD_DUAL_OUT: tx_lanes_q <= `LANES_2;
                    `CMD_DUAL_IO: begin
                      rx_lanes_q <= `LANES_2;
                      tx_lanes_q <= `LANES_2;
                    end
                    `CMD_QUAD_OUT, `CMD_QUAD_IO: begin
                      if (!wide_lane_enable) begin
                        cmd_valid <= 1'b0;
                        cmd_refused <= 1'b1;
                        state_q <= ST_SKIP;
                      end else begin
                        tx_lanes_q <= `LANES_4;
                        if (rx_next == `CMD_QUAD_IO) begin
                          rx_lanes_q <= `LANES_4;
                        end
                      end
                    end
                    default: begin
                      rx_lanes_q <= `LANES_1;
                      tx_lanes_q <= `LANES_1;
                    end
                  endcase
                end else begin
                  rx_valid <= 1'b1;
                end
              end else begin
                cnt_q <= cnt_q + step;
              end
            end
          end
          ST_TX: begin
            if (fall_ok) begin
              io_o <= tx_bits;
              io_oe <= tx_en;
              tx_sh_q <= tx_cur << step;
              if (cnt_q == 4'h0) begin
                tx_req <= 1'b1;
              end
            end
            if (rise_ok) begin
              cnt_q <= (cnt_q + step == 4'h8) ? 4'h0 : cnt_q + step;
            end
          end
          ST_SKIP: begin
            io_oe <= 4'h0;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // flash_spi_front

// ### front_chk_properties.sv
// Port checker of the serial flash front end
module front_chk (
  input logic clk,
  input logic rst_n,
  input logic sclk,
  input logic cs_n,
  input logic [3:0] io_i,
  input logic [3:0] io_oe,
  input logic wide_lane_enable,
  input logic pin_func_reset,
  input logic cmd_valid,
  input logic cmd_refused,
  input logic paused,
  input logic iface_reset,
  input logic hw_reset,
  input logic standby
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] low_q;
  // Saturates so a long low pin never wraps back below the limit
  always @(posedge clk or negedge rst_n)
    if (!rst_n) low_q <= 5'h00;
    else low_q <= io_i[3] ? 5'h00 : low_q + {4'h0, low_q != 5'h1F};
  pause_float_a: assert property (paused ##1 paused |-> io_oe == 4'h0)
    else $error("lanes driven while paused");
  pause_gate_a: assert property (wide_lane_enable || pin_func_reset |=> !paused)
    else $error("pause outside pause mode");
  pause_defer_a: assert property ((!cs_n && sclk) [*3] |-> $stable(paused))
    else $error("pause changed with clock high");
  deselect_reset_a: assert property (paused && cs_n |=> iface_reset && !paused)
    else $error("no interface reset");
  reset_width_a: assert property (hw_reset |-> low_q >= 5'h0A)
    else $error("reset on short pulse");
  reset_idle_a: assert property (hw_reset |=> standby && !hw_reset)
    else $error("no standby after reset");
  quad_refuse_a: assert property (cmd_refused |-> !wide_lane_enable && !cmd_valid)
    else $error("bad refusal");
  quad_gate_a: assert property (io_oe[3:2] != 2'h0 |-> wide_lane_enable)
    else $error("quad lanes without enable");
endmodule // front_chk
bind flash_spi_front front_chk chk_i (.*);

// ### host_model.sv
// Host controller model driving clock, select and data lanes
module host_model (
  input logic clk,
  input logic [3:0] io_i,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_h
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_h = 4'hF;
  end
  task open_frame(input logic idle);
    @(negedge clk) sclk = idle;
    @(negedge clk) cs_n = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task close_frame(input logic idle);
    @(negedge clk) sclk = idle;
    @(negedge clk) cs_n = 1'b1;
    io_h = 4'hF;
    @(negedge clk);
  endtask
  // Data moves on the fall so it is settled at the rise
  task put(input logic [7:0] b, input int n);
    repeat (8 / n) begin
      @(negedge clk) sclk = 1'b0;
      for (int i = 0; i < n; i++)
        io_h[i] = b[8 - n + i];
      b = b << n;
      @(negedge clk);
      @(negedge clk) sclk = 1'b1;
      @(negedge clk);
    end
  endtask
  task get(output logic [7:0] b, input int n);
    io_h[1:0] = ~io_h[1:0];
    b = 8'h00;
    repeat (8 / n) begin
      @(negedge clk) sclk = 1'b0;
      @(negedge clk);
      @(negedge clk) sclk = 1'b1;
      b = b << n;
      for (int i = 0; i < n; i++)
        b[i] = (n == 1) ? io_i[1] : io_i[i];
      @(negedge clk);
    end
  endtask
endmodule // host_model

// ### reset_filter.v
// Low-pulse width filter for a hardware reset pin
`include "flash_front_defs.vh"
module reset_filter #(
  parameter CNT_W = 8,
  parameter integer MIN_CYC = `RESET_PULSE_MIN_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire enable,
  input wire pin_n,
  output wire fire
);
  reg [CNT_W-1:0] cnt_q;
  reg done_q;
  localparam [31:0] MIN_W = MIN_CYC;
  // Last count before firing, cut to the counter width on purpose
  localparam [CNT_W-1:0] LAST_CNT = MIN_W[CNT_W-1:0] - 1'b1;

  // Counts low cycles; fires once per low pulse, then waits for release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {CNT_W{1'b0}};
      done_q <= 1'b0;
    end else if (!enable || pin_n) begin
      cnt_q <= {CNT_W{1'b0}};
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == LAST_CNT) begin
        done_q <= 1'b1;
      end
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign fire = enable & ~pin_n & ~done_q & (cnt_q == LAST_CNT);
endmodule // reset_filter

// ### sclk_edge.v
// Edge finder for the serial clock, sampled on the system clock
module sclk_edge (
  input wire clk,
  input wire rst_n,
  input wire sclk,
  output wire rise,
  output wire fall
);
  reg sclk_q;

  // Resets low so a mode 3 idle-high clock gives one early rise while
  // chip select is still high, where it is ignored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
endmodule // sclk_edge

// ### tb_serial_flash_bus_hold_reset.sv
// Self-checking bench of the serial flash front end
module tb_serial_flash_bus_hold_reset;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wide_lane_enable = 1'b0;
  logic pin_func_reset = 1'b0;
  logic tx_dir = 1'b0;
  logic hold_n = 1'b1;
  logic reset_pin_n = 1'b1;
  logic [7:0] tx_data = 8'hA5;
  logic sclk, cs_n, tx_req, rx_valid, cmd_valid, cmd_refused;
  logic paused, iface_reset, hw_reset, standby;
  logic [3:0] io_h, io_i, io_o, io_oe;
  logic [7:0] rx_byte, b;
  logic [7:0] n_cmd = 8'h00, n_rx = 8'h00, n_ref = 8'h00, n_ifr = 8'h00, n_hw = 8'h00;
  logic [7:0] n_txr = 8'h00, n_ded = 8'h00;
  logic ded_hw;
  int failures = 0;
  int n_compared = 0;
  assign io_i = (io_oe & io_o) | (~io_oe & {io_h[3] & hold_n, io_h[2:0]});
  flash_spi_front dut (.*);
  host_model host (.clk, .io_i, .sclk, .cs_n, .io_h);
  // Build with a dedicated reset pin; its shared pin is a plain data lane
  flash_spi_front #(.HAS_DEDICATED_RESET(1)) dut_ded (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(1'b0),
    .cs_n(1'b1),
    .io_i({reset_pin_n, 3'h7}),
    .io_o(),
    .io_oe(),
    .reset_pin_n(reset_pin_n),
    .wide_lane_enable(1'b1),
    .pin_func_reset(1'b0),
    .tx_dir(1'b0),
    .tx_data(8'h00),
    .tx_req(),
    .rx_byte(),
    .rx_valid(),
    .cmd_valid(),
    .cmd_refused(),
    .paused(),
    .iface_reset(),
    .hw_reset(ded_hw),
    .standby()
  );
  always #50 clk = ~clk;
  always @(posedge clk) begin
    n_cmd <= n_cmd + cmd_valid;
    n_rx <= n_rx + rx_valid;
    n_ref <= n_ref + cmd_refused;
    n_ifr <= n_ifr + iface_reset;
    n_hw <= n_hw + hw_reset;
    n_txr <= n_txr + tx_req;
    n_ded <= n_ded + ded_hw;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task frame(input logic [7:0] cmd, input int ni, input int no, input logic idle);
    logic [7:0] c, t;
    c = n_cmd;
    t = n_txr;
    tx_dir = 1'b0;
    host.open_frame(idle);
    host.put(cmd, 1);
    tx_dir = 1'b1;
    host.put(8'h3C, ni);
    host.get(b, no);
    chk("tx req", t + 8'h01, n_txr);
    host.close_frame(idle);
    chk("cmd count", c + 8'h01, n_cmd);
    chk("rx byte", 8'h3C, rx_byte);
    chk("tx byte", tx_data, b);
  endtask
  task t_lanes;
    logic [7:0] cmds [5] = '{8'h05, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
    int ni [5] = '{1, 1, 2, 1, 4};
    int no [5] = '{1, 2, 2, 4, 4};
    wide_lane_enable = 1'b1;
    for (int i = 0; i < 5; i++)
      frame(cmds[i], ni[i], no[i], i[0]);
    $display("t_lanes done");
  endtask
  task t_refuse;
    logic [7:0] r, c;
    r = n_ref;
    c = n_cmd;
    wide_lane_enable = 1'b0;
    tx_dir = 1'b1;
    host.open_frame(1'b0);
    host.put(8'hEB, 1);
    host.put(8'h3C, 1);
    host.close_frame(1'b0);
    chk("refused", r + 8'h01, n_ref);
    chk("cmd count", c, n_cmd);
    $display("t_refuse done");
  endtask
  task t_pause;
    logic [7:0] r, f;
    r = n_rx;
    f = n_ifr;
    tx_dir = 1'b0;
    host.open_frame(1'b0);
    host.put(8'h05, 1);
    hold_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("deferred start", 8'h00, {7'h0, paused});
    host.sclk = 1'b0;
    repeat (2) @(negedge clk);
    chk("paused", 8'h01, {7'h0, paused});
    // Clock and data while paused must leave the bit count alone
    host.put(8'hFF, 1);
    hold_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("deferred end", 8'h01, {7'h0, paused});
    host.put(8'h3C, 1);
    // The byte counters move one edge after the pulse
    @(negedge clk);
    chk("resumed byte", 8'h3C, rx_byte);
    chk("rx count", r + 8'h01, n_rx);
    hold_n = 1'b0;
    host.sclk = 1'b0;
    repeat (2) @(negedge clk);
    host.close_frame(1'b0);
    repeat (2) @(negedge clk);
    chk("iface reset", f + 8'h01, n_ifr);
    hold_n = 1'b1;
    frame(8'h05, 1, 1, 1'b0);
    // Pause in the send phase must release the output lane
    tx_dir = 1'b1;
    host.open_frame(1'b0);
    host.put(8'h05, 1);
    host.sclk = 1'b0;
    repeat (2) @(negedge clk);
    chk("lanes driven", 8'h02, {4'h0, io_oe});
    hold_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("paused float", 8'h00, {4'h0, io_oe});
    hold_n = 1'b1;
    repeat (2) @(negedge clk);
    host.close_frame(1'b0);
    $display("t_pause done");
  endtask
  task pulse(input int n);
    hold_n = 1'b0;
    repeat (n) @(negedge clk);
    hold_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task t_reset;
    logic [7:0] h, d;
    h = n_hw;
    pin_func_reset = 1'b1;
    pulse(8);
    chk("short pulse", h, n_hw);
    pulse(13);
    chk("long pulse", h + 8'h01, n_hw);
    chk("standby", 8'h01, {7'h0, standby});
    wide_lane_enable = 1'b1;
    pulse(13);
    chk("lane mode pulse", h + 8'h01, n_hw);
    d = n_ded;
    reset_pin_n = 1'b0;
    repeat (13) @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("dedicated pin", d + 8'h01, n_ded);
    chk("no dedicated pin", h + 8'h01, n_hw);
    $display("t_reset done");
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("standby", 8'h01, {7'h0, standby});
    t_lanes();
    t_refuse();
    t_pause();
    t_reset();
    close_out();
  end
  // Whole run is near 800 cycles, so 1 ms leaves wide margin
  initial begin
    #1000000;
    failures++;
    close_out();
  end
endmodule // tb_serial_flash_bus_hold_reset
